//--- design/serial_port_pkg.sv
/*
 * Constants for the serial port register interface: offsets, field
 * positions, reset values and timing counts.
 * Assumes a 32-bit register port with one-cycle read latency.
 */
package serial_port_pkg;
	localparam logic [31:0] CHAN_A_BASE      = 32'hFF018000;
	localparam logic [31:0] CHAN_B_BASE      = 32'hFF01C000;
	localparam logic [31:0] CHAN_SPAN_MASK   = 32'h00003FFF;
	localparam logic [7:0]  OFF_COMMAND      = 8'h00;
	localparam logic [7:0]  OFF_MODE         = 8'h04;
	localparam logic [7:0]  OFF_IRQ_SET      = 8'h08;
	localparam logic [7:0]  OFF_IRQ_CLR      = 8'h0C;
	localparam logic [7:0]  OFF_IRQ_MASK     = 8'h10;
	localparam logic [7:0]  OFF_FLAGS        = 8'h14;
	localparam logic [7:0]  OFF_RX_HOLD      = 8'h18;
	localparam logic [7:0]  OFF_TX_HOLD      = 8'h1C;
	localparam logic [7:0]  OFF_BAUD_DIV     = 8'h20;
	localparam logic [7:0]  OFF_RX_TIMEOUT   = 8'h24;
	localparam logic [7:0]  OFF_TX_GUARD     = 8'h28;
	localparam logic [7:0]  OFF_RX_PTR       = 8'h30;
	localparam logic [7:0]  OFF_RX_CNT       = 8'h34;
	localparam logic [7:0]  OFF_TX_PTR       = 8'h38;
	localparam logic [7:0]  OFF_TX_CNT       = 8'h3C;
	localparam logic [7:0]  OFF_MODEM_CTRL   = 8'h40;
	localparam logic [7:0]  OFF_MODEM_STATE  = 8'h44;
	// Command bits
	localparam int CMD_RX_RESET  = 2;
	localparam int CMD_TX_RESET  = 3;
	localparam int CMD_RX_ON     = 4;
	localparam int CMD_RX_OFF    = 5;
	localparam int CMD_TX_ON     = 6;
	localparam int CMD_TX_OFF    = 7;
	localparam int CMD_CLR_ERR   = 8;
	localparam int CMD_BRK_BEGIN = 9;
	localparam int CMD_BRK_END   = 10;
	localparam int CMD_TO_ARM    = 11;
	localparam int CMD_ADDR_CHAR = 12;
	// Mode fields
	localparam int MODE_CLKSRC_LSB = 4;
	localparam int MODE_CHAR_LENGTH_SEL_LSB   = 6;
	localparam int MODE_SYNC       = 8;
	localparam int MODE_PAR_LSB    = 9;
	localparam int MODE_STOP_LSB   = 12;
	localparam int MODE_CHANNEL_TEST_MODE_LSB = 14;
	localparam int MODE_NINE_BIT   = 17;
	localparam int MODE_CLK_DRIVE  = 18;
	localparam logic [31:0] MODE_WRITE_MASK = 32'h0006FFF0;
	localparam logic [31:0] MODE_RESET      = 32'h00000000;
	// Status bits
	localparam int ST_RX_READY   = 0;
	localparam int ST_TX_READY   = 1;
	localparam int ST_BREAK_SEEN = 2;
	localparam int ST_RX_DONE    = 3;
	localparam int ST_TX_DONE    = 4;
	localparam int ST_OVERRUN    = 5;
	localparam int ST_FRAMING    = 6;
	localparam int ST_PARITY     = 7;
	localparam int ST_TIMEOUT    = 8;
	localparam int ST_TX_IDLE    = 9;
	localparam int ST_MODEM_CHG  = 10;
	localparam int ST_WIDTH      = 11;
	localparam logic [10:0] FLAGS_RESET      = 11'h018;
	localparam logic [10:0] FLAGS_RESET_ALT  = 11'h418;
	localparam logic [10:0] ERR_FLAG_MASK    = 11'h0E4;
	// Timing
	localparam int BREAK_TAIL_BITS = 12;
endpackage

//--- design/serial_port_regs.sv
/*
 * One channel of the serial port: register file, command decoding,
 * mode-driven framing, break sequencing, echo and loopback paths.
 * Assumes a single-cycle master on the plain register port; line and
 * modem pins come from outside and are synchronised here.
 */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

// Behaviour
// - Two channels at distinct base addresses.
// - Flag reset value follows boot input; modem sample is still zero at capture.
// - Modem state reflects inverted modem input levels.
// - Reset commands reset receiver or transmitter.
// - Receiver on unless off in same write.
// - Transmitter on unless off in same write.
// - Clear command clears four error flags.
// - Break begins once shift is empty, ahead of any held character.
// - Break end after character, then twelve high bits.
// - Timeout arm waits for next character.
// - Address command marks next multidrop character.
// - Clock source selects clock, divide eight, pin.
// - Character length five to eight bits.
// - Sync bit selects asynchronous or synchronous.
// - Parity field selects parity or multidrop.
// - Stop field gives one, one-half, two stops; one-half is sent as two, or as one in synchronous mode.
// - Channel mode normal, echo, local, remote.
// - Nine-bit select overrides character length.
// - Drive clock pin only when allowed.
// - Enable-set register sets mask bits.
// - Interrupt source bits ordered zero to ten.
// - Interrupt when flag and mask both set.
// - Enable-clear register clears mask bits.
// - Transmitter on sets ready and idle.
module serial_port_regs #(
	parameter logic [31:0] BASE_ADDR = serial_port_pkg::CHAN_A_BASE
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic [31:0] regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdata,
	input  wire logic        bootStrap,
	input  wire logic        rxdPin,
	output logic             txdPin,
	input  wire logic        sckIn,
	output logic             sckOut,
	output logic             sckOe_n,
	input  wire logic [3:0]  modemIn_n,
	output logic      [1:0]  modemOut_n,
	output logic             chanIrq
);
	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_SHIFT = 4'b0010,
		TX_BREAK = 4'b0100,
		TX_TAIL  = 4'b1000
	} txState_t;

	typedef struct packed {
		logic [1:0]  rxdSync;
		logic [1:0]  sckSync;
		logic [11:0] modemSync;
		logic        strapDone;
		logic [31:0] mode;
		logic [10:0] mask;
		logic [10:0] flags;
		logic        rxOn;
		logic        txOn;
		logic        addrPend;
		logic        toArmed;
		logic        brkPend;
		logic        brkEndReq;
		logic        holdFull;
		logic [8:0]  holdData;
		logic        holdAddr;
		txState_t    txState;
		logic [11:0] txShift;
		logic [3:0]  txBits;
		logic [15:0] baudCnt;
		logic [2:0]  div8;
		logic        sckPrev;
		logic        sckDrv;
		logic [15:0] brkCnt;
		logic [8:0]  rxData;
		logic [3:0]  rxLeft;
		logic [9:0]  rxSh;
		logic [31:0] baudDiv;
		logic [31:0] rxTimeout;
		logic [31:0] txGuard;
		logic [31:0] rxPtr;
		logic [31:0] rxCnt;
		logic [31:0] txPtr;
		logic [31:0] txCnt;
		logic [1:0]  modemCtl;
		logic        txd;
		logic [31:0] rdata;
	} state_t;

	state_t   s_q;
	state_t   s_d;
	logic     hit;
	logic [7:0] off;
	logic     wr;
	logic     tick;
	logic     txLine;
	logic [3:0] charLen;
	logic [1:0] channel_test_mode;
	logic     parBit;

	////////////////////////////////////////////////////////////////////
	// Decode

	assign hit = (regAddr & ~serial_port_pkg::CHAN_SPAN_MASK) ==
		(BASE_ADDR & ~serial_port_pkg::CHAN_SPAN_MASK);
	assign off = regAddr[7:0];
	assign wr  = regWrite & hit;
	assign channel_test_mode = s_q.mode[serial_port_pkg::MODE_CHANNEL_TEST_MODE_LSB +: 2];

	always_comb begin
		if (s_q.mode[serial_port_pkg::MODE_NINE_BIT]) begin
			charLen = 4'h9;
		end else begin
			charLen = 4'h5 +
				{2'h0, s_q.mode[serial_port_pkg::MODE_CHAR_LENGTH_SEL_LSB +: 2]};
		end
	end

	always_comb begin
		case (s_q.mode[serial_port_pkg::MODE_PAR_LSB +: 3])
			3'h0:    parBit = ^s_q.holdData;
			3'h1:    parBit = ~^s_q.holdData;
			3'h2:    parBit = 1'b0;
			3'h3:    parBit = 1'b1;
			default: parBit = s_q.holdAddr;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Baud tick: clock source selection

	always_comb begin
		case (s_q.mode[serial_port_pkg::MODE_CLKSRC_LSB +: 2])
			2'h0:    tick = 1'b1;
			2'h1:    tick = (s_q.div8 == 3'h7);
			default: tick = s_q.sckSync[1] & ~s_q.sckPrev;
		endcase
	end

	// Echo and remote loopback bypass the transmitter entirely
	always_comb begin
		case (channel_test_mode)
			2'h1:    txLine = s_q.rxdSync[1];
			2'h2:    txLine = 1'b1;
			2'h3:    txLine = s_q.rxdSync[1];
			default: txLine = s_q.txShift[0] | (s_q.txState == TX_IDLE);
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [11:0] frame;
		logic [3:0]  nStop;
		logic        bitTick;
		logic        rxLine;
		frame   = 12'h000;
		nStop   = 4'h1;
		bitTick = 1'b0;
		rxLine  = 1'b1;
		s_d = s_q;
		s_d.rxdSync   = {s_q.rxdSync[0], rxdPin};
		s_d.sckSync   = {s_q.sckSync[0], sckIn};
		s_d.modemSync = {s_q.modemSync[7:0], ~modemIn_n};
		s_d.sckPrev   = s_q.sckSync[1];
		s_d.div8      = s_q.div8 + 3'h1;
		s_d.txd       = txLine;

		// Strap caught after reset release
		if (!s_q.strapDone) begin
			s_d.strapDone = 1'b1;
			if (bootStrap | s_q.modemSync[5]) begin
				s_d.flags = serial_port_pkg::FLAGS_RESET_ALT;
			end
		end

		// Baud divisor gates bit periods
		if (tick) begin
			if (s_q.baudCnt >= s_q.baudDiv[15:0]) begin
				s_d.baudCnt = 16'h0000;
				bitTick = 1'b1;
			end else begin
				s_d.baudCnt = s_q.baudCnt + 16'h0001;
			end
		end
		s_d.sckDrv = bitTick ? ~s_q.sckDrv : s_q.sckDrv;

		// Modem input change
		if (s_q.modemSync[11:8] != s_q.modemSync[7:4]) begin
			s_d.flags[serial_port_pkg::ST_MODEM_CHG] = 1'b1;
		end

		// stop bits; 1.5 rounded up to 2 on the shift path, down to 1 in synchronous mode
		nStop = s_q.mode[serial_port_pkg::MODE_STOP_LSB +: 2] == 2'h0 ?
			4'h1 : 4'h2;
		if (s_q.mode[serial_port_pkg::MODE_SYNC]) begin
			nStop = s_q.mode[serial_port_pkg::MODE_STOP_LSB + 1] ?
				4'h2 : 4'h1;
		end

		// Transmitter
		case (s_q.txState)
			TX_IDLE: begin
				if (s_q.brkPend && s_q.txOn) begin
					s_d.txState = TX_BREAK;
					s_d.brkPend = 1'b0;
					s_d.txShift = 12'h000;
					s_d.brkCnt  = 16'h0000;
					s_d.flags[serial_port_pkg::ST_TX_IDLE] = 1'b0;
					s_d.flags[serial_port_pkg::ST_TX_READY] = 1'b1;
				end else if (s_q.holdFull && s_q.txOn && bitTick) begin
					frame = 12'hFFF;
					frame[0] = 1'b0;
					frame[9:1] = s_q.holdData | (9'h1FF << charLen);
					if (!s_q.mode[serial_port_pkg::MODE_PAR_LSB + 2] ||
						s_q.mode[serial_port_pkg::MODE_PAR_LSB + 1]) begin
						frame[charLen + 4'h1] = parBit;
					end
					s_d.txShift  = frame;
					s_d.txBits   = charLen + 4'h2 + nStop;
					s_d.txState  = TX_SHIFT;
					s_d.holdFull = 1'b0;
					s_d.flags[serial_port_pkg::ST_TX_READY] = ~s_q.brkPend;
				end else if (!s_q.holdFull && s_q.txOn &&
					!s_q.brkPend) begin
					s_d.flags[serial_port_pkg::ST_TX_IDLE] = 1'b1;
				end
			end
			TX_SHIFT: begin
				if (bitTick) begin
					s_d.txShift = {1'b1, s_q.txShift[11:1]};
					s_d.txBits  = s_q.txBits - 4'h1;
					if (s_q.txBits == 4'h1) begin
						s_d.txState = TX_IDLE;
					end
				end
			end
			TX_BREAK: begin
				if (bitTick && s_q.brkCnt != 16'hFFFF) begin
					s_d.brkCnt = s_q.brkCnt + 16'h0001;
				end
				if (s_q.brkEndReq &&
					s_q.brkCnt >= {12'h000, charLen} + 16'h0002) begin
					s_d.txState   = TX_TAIL;
					s_d.brkEndReq = 1'b0;
					s_d.txShift   = 12'hFFF;
					s_d.brkCnt    = 16'h0000;
				end
			end
			TX_TAIL: begin
				if (bitTick) begin
					s_d.brkCnt = s_q.brkCnt + 16'h0001;
					if (s_q.brkCnt ==
						16'(serial_port_pkg::BREAK_TAIL_BITS - 1)) begin
						s_d.txState = TX_IDLE;
					end
				end
			end
			default: s_d.txState = TX_IDLE;
		endcase

		// Receiver: local loopback feeds transmitter output back
		rxLine = (channel_test_mode == 2'h2) ? s_q.txShift[0] : s_q.rxdSync[1];

		// Register writes
		if (wr) begin
			case (off)
				serial_port_pkg::OFF_COMMAND: begin
					if (regWdata[serial_port_pkg::CMD_RX_RESET]) begin
						s_d.rxData = 9'h000;
						s_d.toArmed = 1'b0;
						s_d.flags[serial_port_pkg::ST_RX_READY] = 1'b0;
					end
					if (regWdata[serial_port_pkg::CMD_TX_RESET]) begin
						s_d.txState  = TX_IDLE;
						s_d.holdFull = 1'b0;
						s_d.brkPend  = 1'b0;
						s_d.brkEndReq = 1'b0;
						s_d.addrPend = 1'b0;
					end
					if (regWdata[serial_port_pkg::CMD_RX_OFF]) begin
						s_d.rxOn = 1'b0;
						s_d.flags[serial_port_pkg::ST_RX_READY] = 1'b0;
					end else if (regWdata[serial_port_pkg::CMD_RX_ON]) begin
						s_d.rxOn = 1'b1;
					end
					if (regWdata[serial_port_pkg::CMD_TX_OFF]) begin
						s_d.txOn = 1'b0;
						s_d.flags[serial_port_pkg::ST_TX_READY] = 1'b0;
						s_d.flags[serial_port_pkg::ST_TX_IDLE]  = 1'b0;
					end else if (regWdata[serial_port_pkg::CMD_TX_ON]) begin
						s_d.txOn = 1'b1;
						s_d.flags[serial_port_pkg::ST_TX_READY] = 1'b1;
						s_d.flags[serial_port_pkg::ST_TX_IDLE]  = 1'b1;
					end
					if (regWdata[serial_port_pkg::CMD_CLR_ERR]) begin
						s_d.flags = s_d.flags &
							~serial_port_pkg::ERR_FLAG_MASK;
					end
					if (regWdata[serial_port_pkg::CMD_BRK_BEGIN] &&
						s_q.txState != TX_BREAK && !s_q.brkPend) begin
						s_d.brkPend = 1'b1;
						s_d.flags[serial_port_pkg::ST_TX_READY] = 1'b0;
					end
					if (regWdata[serial_port_pkg::CMD_BRK_END] &&
						s_q.txState == TX_BREAK) begin
						s_d.brkEndReq = 1'b1;
					end
					if (regWdata[serial_port_pkg::CMD_TO_ARM]) begin
						s_d.toArmed = 1'b1;
						s_d.flags[serial_port_pkg::ST_TIMEOUT] = 1'b0;
					end
					if (regWdata[serial_port_pkg::CMD_ADDR_CHAR] &&
						s_q.mode[serial_port_pkg::MODE_PAR_LSB + 1 +: 2] ==
						2'h3) begin
						s_d.addrPend = 1'b1;
					end
				end
				serial_port_pkg::OFF_MODE:
					s_d.mode = regWdata &
						serial_port_pkg::MODE_WRITE_MASK;
				serial_port_pkg::OFF_IRQ_SET:
					s_d.mask = s_q.mask | regWdata[10:0];
				serial_port_pkg::OFF_IRQ_CLR:
					s_d.mask = s_q.mask & ~regWdata[10:0];
				serial_port_pkg::OFF_TX_HOLD: begin
					if (!s_q.brkPend && s_q.txOn) begin
						s_d.holdFull = 1'b1;
						s_d.holdData = regWdata[8:0];
						s_d.holdAddr = s_q.addrPend;
						s_d.addrPend = 1'b0;
						s_d.flags[serial_port_pkg::ST_TX_READY] = 1'b0;
						s_d.flags[serial_port_pkg::ST_TX_IDLE]  = 1'b0;
					end
				end
				serial_port_pkg::OFF_BAUD_DIV:   s_d.baudDiv   = regWdata;
				serial_port_pkg::OFF_RX_TIMEOUT: s_d.rxTimeout = regWdata;
				serial_port_pkg::OFF_TX_GUARD:   s_d.txGuard   = regWdata;
				serial_port_pkg::OFF_RX_PTR:     s_d.rxPtr     = regWdata;
				serial_port_pkg::OFF_RX_CNT:     s_d.rxCnt     = regWdata;
				serial_port_pkg::OFF_TX_PTR:     s_d.txPtr     = regWdata;
				serial_port_pkg::OFF_TX_CNT:     s_d.txCnt     = regWdata;
				serial_port_pkg::OFF_MODEM_CTRL:
					s_d.modemCtl = regWdata[1:0];
				default: ;
			endcase
		end

		// Receiver after writes so a flag set beats a clear
		if (s_q.rxOn && channel_test_mode != 2'h3 && bitTick) begin
			if (s_q.rxLeft != 4'h0) begin
				s_d.rxSh   = {rxLine, s_q.rxSh[9:1]};
				s_d.rxLeft = s_q.rxLeft - 4'h1;
			end else if (!rxLine) begin
				s_d.rxLeft  = charLen + 4'h1;
				s_d.toArmed = 1'b0;
			end
			if (s_q.rxLeft == 4'h1) begin
				s_d.rxData = s_d.rxSh[8:0] >> (4'h9 - charLen);
				s_d.flags[serial_port_pkg::ST_RX_READY] = 1'b1;
				s_d.flags[serial_port_pkg::ST_FRAMING] |= !rxLine;
			end
		end

		// Reads: unmapped and write-only offsets return zero
		s_d.rdata = 32'h00000000;
		if (regRead && hit) begin
			case (off)
				serial_port_pkg::OFF_MODE:       s_d.rdata = s_q.mode;
				serial_port_pkg::OFF_IRQ_MASK:
					s_d.rdata = {21'h000000, s_q.mask};
				serial_port_pkg::OFF_FLAGS:
					s_d.rdata = {21'h000000, s_q.flags};
				serial_port_pkg::OFF_RX_HOLD:
					s_d.rdata = {23'h000000, s_q.rxData};
				serial_port_pkg::OFF_BAUD_DIV:   s_d.rdata = s_q.baudDiv;
				serial_port_pkg::OFF_RX_TIMEOUT: s_d.rdata = s_q.rxTimeout;
				serial_port_pkg::OFF_TX_GUARD:   s_d.rdata = s_q.txGuard;
				serial_port_pkg::OFF_RX_PTR:     s_d.rdata = s_q.rxPtr;
				serial_port_pkg::OFF_RX_CNT:     s_d.rdata = s_q.rxCnt;
				serial_port_pkg::OFF_TX_PTR:     s_d.rdata = s_q.txPtr;
				serial_port_pkg::OFF_TX_CNT:     s_d.rdata = s_q.txCnt;
				serial_port_pkg::OFF_MODEM_STATE:
					s_d.rdata = {24'h000000, s_q.modemSync[7:4], 4'h0};
				default: s_d.rdata = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.rxdSync <= 2'h3;
			s_q.mode    <= serial_port_pkg::MODE_RESET;
			s_q.flags   <= serial_port_pkg::FLAGS_RESET;
			s_q.txState <= TX_IDLE;
			s_q.txShift <= 12'hFFF;
			s_q.txd     <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdata   = s_q.rdata;
	assign txdPin     = s_q.txd;
	assign sckOut     = s_q.sckDrv;
	assign sckOe_n    = ~(s_q.mode[serial_port_pkg::MODE_CLK_DRIVE] &
		~s_q.mode[serial_port_pkg::MODE_CLKSRC_LSB + 1]);
	assign modemOut_n = ~s_q.modemCtl;
	assign chanIrq    = |(s_q.flags & s_q.mask);
endmodule

//--- test/serial_port_props.sv
/*
 * Port checker for one serial channel.
 * Assumes it is bound into serial_port_regs and sees only its ports.
 */
`timescale 1ns/1ps

module serial_port_props #(
	parameter logic [31:0] BASE_ADDR = serial_port_pkg::CHAN_A_BASE
) (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [31:0] regRdata,
	input wire logic        bootStrap,
	input wire logic        rxdPin,
	input wire logic        txdPin,
	input wire logic        sckIn,
	input wire logic        sckOut,
	input wire logic        sckOe_n,
	input wire logic [3:0]  modemIn_n,
	input wire logic [1:0]  modemOut_n,
	input wire logic        chanIrq
);
	typedef struct packed {
		logic [31:0] mode;
		logic [10:0] mask;
	} shadow_t;
	shadow_t    shQ;
	shadow_t    shD;
	logic       wr;
	logic       rd;
	logic [7:0] offs;
	assign offs = regAddr[7:0];
	assign wr = regWrite && regAddr[31:14] == BASE_ADDR[31:14];
	assign rd = regRead && regAddr[31:14] == BASE_ADDR[31:14];
	////////////////////////////////////////////////////////////////////////
	// Shadow of software writes
	always_comb begin
		shD = shQ;
		if (wr && offs == serial_port_pkg::OFF_MODE)
			shD.mode = regWdata & serial_port_pkg::MODE_WRITE_MASK;
		if (wr && offs == serial_port_pkg::OFF_IRQ_SET)
			shD.mask = shQ.mask | regWdata[10:0];
		if (wr && offs == serial_port_pkg::OFF_IRQ_CLR)
			shD.mask = shQ.mask & ~regWdata[10:0];
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			shQ <= '0;
		else
			shQ <= shD;
	end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	rdata_idle_a: assert property (
		!$past(regRead) |-> regRdata == 32'h0)
		else $error("read data not zero outside read answer");
	wo_read_a: assert property (
		rd && (offs == serial_port_pkg::OFF_COMMAND ||
		offs == serial_port_pkg::OFF_TX_HOLD) |=> regRdata == 32'h0)
		else $error("write-only register read not zero");
	mode_view_a: assert property (
		rd && offs == serial_port_pkg::OFF_MODE |=>
		regRdata == $past(shQ.mode))
		else $error("mode view differs from written mode");
	mask_view_a: assert property (
		rd && offs == serial_port_pkg::OFF_IRQ_MASK |=>
		regRdata == {21'h0, $past(shQ.mask)})
		else $error("mask view differs from set and clear history");
	mask_clear_a: assert property (
		wr && offs == serial_port_pkg::OFF_IRQ_CLR &&
		regWdata[10:0] == 11'h7FF |=> !chanIrq)
		else $error("interrupt stays after all sources disabled");
	irq_gate_a: assert property (
		chanIrq |-> shQ.mask != 11'h0)
		else $error("interrupt with every source masked");
	clk_pin_a: assert property (
		sckOe_n == !(shQ.mode[18] && !shQ.mode[5]))
		else $error("clock pin enable wrong for mode");
	modem_view_a: assert property (
		$stable(modemIn_n) [*4] ##0
		(rd && offs == serial_port_pkg::OFF_MODEM_STATE) |=>
		regRdata[7:4] == ~$past(modemIn_n))
		else $error("modem view does not follow inputs");
	txon_irq_a: assert property (
		wr && offs == serial_port_pkg::OFF_COMMAND && regWdata[6] &&
		!regWdata[7] && !regWdata[3] && !regWdata[9] && shQ.mask[1]
		|-> ##[1:2] chanIrq)
		else $error("transmitter on gave no ready interrupt");
	cover property (rd && offs == serial_port_pkg::OFF_FLAGS);
	cover property (chanIrq);
	cover property (!sckOe_n);
endmodule

bind serial_port_regs serial_port_props #(.BASE_ADDR(BASE_ADDR)) props_i (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
	.regRdata(regRdata), .bootStrap(bootStrap), .rxdPin(rxdPin),
	.txdPin(txdPin), .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n),
	.modemIn_n(modemIn_n), .modemOut_n(modemOut_n), .chanIrq(chanIrq));

//--- test/serial_line_model.sv
/*
 * Far end of the serial line: terminal and modem levels.
 * Assumes bit timing in whole clock cycles given by the caller.
 */
`timescale 1ns/1ps

module serial_line_model (
	input  wire logic       sys_clk,
	input  wire logic       txdPin,
	output logic            rxdPin,
	output logic            sckIn,
	output logic [3:0]      modemIn_n
);
	// Idle line sits at the pull-up level; clock only moves inside frames
	initial begin
		rxdPin = 1'b1;
		sckIn = 1'b0;
		modemIn_n = 4'hF;
	end
	task automatic send(input logic [7:0] d, input logic stp, input int b);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		@(posedge sys_clk);
		for (int i = 0; i < 10; i++) begin
			rxdPin <= f[i];
			sckIn <= ~sckIn;
			repeat (b) @(posedge sys_clk);
		end
		rxdPin <= 1'b1;
	endtask
	// Data bits land LSB first at 0..n-1, stop level at n
	task automatic grab(input int n, input int b, output logic [9:0] d);
		d = 10'h0;
		for (int k = 0; k < 4000 && txdPin !== 1'b0; k++)
			@(posedge sys_clk);
		repeat (b / 2) @(posedge sys_clk);
		for (int i = 0; i <= n; i++) begin
			repeat (b) @(posedge sys_clk);
			d[i] = txdPin;
		end
	endtask
	task automatic level(input logic v);
		@(posedge sys_clk);
		rxdPin <= v;
	endtask
	task automatic modem(input logic [3:0] v);
		@(posedge sys_clk);
		modemIn_n <= v;
	endtask
endmodule

//--- test/testbench.sv
/*
 * Self-checking bench for one serial channel.
 * Assumes the line model on the pins and the checker bound in.
 */
`timescale 1ns/1ps

module testbench;
	localparam int BIT = 4;
	localparam logic [7:0] ZOFF [16] = '{8'h00, 8'h04, 8'h08, 8'h0C,
		8'h10, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34,
		8'h38, 8'h3C, 8'h40};
	localparam logic [31:0] TXM [5] = '{32'h800, 32'h840, 32'h880,
		32'h8C0, 32'h20800};
	localparam logic [9:0] TXE [5] = '{10'h02B, 10'h04B, 10'h08B,
		10'h10B, 10'h30B};
	localparam logic [31:0] LBM [3] = '{32'h48C0, 32'h88C0, 32'hC8C0};
	logic        sys_clk;
	logic        sys_rst;
	logic [31:0] regAddr;
	logic [31:0] regWdata;
	logic        regWrite;
	logic        regRead;
	logic [31:0] regRdata;
	logic        bootStrap;
	logic        rxdPin;
	logic        txdPin;
	logic        sckIn;
	logic        sckOut;
	logic        sckOe_n;
	logic [3:0]  modemIn_n;
	logic [1:0]  modemOut_n;
	logic        chanIrq;
	logic [31:0] base;
	logic [31:0] v;
	logic [9:0]  got;
	int          n_fail = 0;
	int          checked = 0;
	int          cyc = 0;
	int          t0;
	int          t1;
	serial_port_regs serial_port_regs_i (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.bootStrap(bootStrap), .rxdPin(rxdPin), .txdPin(txdPin),
		.sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n),
		.modemIn_n(modemIn_n), .modemOut_n(modemOut_n), .chanIrq(chanIrq));
	serial_line_model serial_line_model_i (.sys_clk(sys_clk),
		.txdPin(txdPin), .rxdPin(rxdPin), .sckIn(sckIn),
		.modemIn_n(modemIn_n));
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic close_out;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// A clock edge always passes before a strobe rises again
	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= base | {24'h0, off};
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] off, output logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= base | {24'h0, off};
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic rchk(input logic [7:0] off, input logic [31:0] e);
		logic [31:0] r;
		rd(off, r);
		chk(r, e);
	endtask
	task automatic restart(input logic strap);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		bootStrap <= strap;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
	endtask
	task automatic togs(output int t);
		logic p;
		t = 0;
		p = sckOut;
		repeat (64) begin
			@(posedge sys_clk);
			#1 if (sckOut !== p) t++;
			p = sckOut;
		end
	endtask
	task automatic txchk(input logic [31:0] m, input logic [31:0] c,
		input int n, input logic [9:0] e);
		wr(serial_port_pkg::OFF_MODE, m);
		if (c != 32'h0) wr(serial_port_pkg::OFF_COMMAND, c);
		fork
			serial_line_model_i.grab(n, BIT, got);
			wr(serial_port_pkg::OFF_TX_HOLD, 32'h10B);
		join
		chk({22'h0, got}, {22'h0, e});
		repeat (2 * BIT) @(posedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		regAddr = 32'h0;
		regWdata = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		bootStrap = 1'b0;
		base = serial_port_pkg::CHAN_A_BASE;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rchk(serial_port_pkg::OFF_FLAGS, 32'h18);
		foreach (ZOFF[i]) rchk(ZOFF[i], 32'h0);
		restart(1'b1);
		rchk(serial_port_pkg::OFF_FLAGS, 32'h418);
		restart(1'b0);
		rchk(serial_port_pkg::OFF_FLAGS, 32'h18);
		wr(serial_port_pkg::OFF_MODE, 32'hFFFFFFFF);
		rchk(serial_port_pkg::OFF_MODE, 32'h0006FFF0);
		base = serial_port_pkg::CHAN_B_BASE;
		wr(serial_port_pkg::OFF_MODE, 32'h0);
		base = serial_port_pkg::CHAN_A_BASE;
		rchk(serial_port_pkg::OFF_MODE, 32'h0006FFF0);
		wr(serial_port_pkg::OFF_MODE, 32'h00040020);
		chk({31'h0, sckOe_n}, 32'h1);
		wr(serial_port_pkg::OFF_MODE, 32'h00040010);
		togs(t1);
		wr(serial_port_pkg::OFF_MODE, 32'h00040000);
		chk({31'h0, sckOe_n}, 32'h0);
		togs(t0);
		chk({31'h0, t1 > 0 && t0 >= 4 * t1}, 32'h1);
		wr(serial_port_pkg::OFF_MODE, 32'h0);
		for (int i = 0; i < 11; i++) begin
			wr(serial_port_pkg::OFF_IRQ_SET, 32'h1 << i);
			rchk(serial_port_pkg::OFF_IRQ_MASK, (32'h2 << i) - 1);
		end
		chk({31'h0, chanIrq}, 32'h1);
		wr(serial_port_pkg::OFF_IRQ_CLR, 32'h7E7);
		rchk(serial_port_pkg::OFF_IRQ_MASK, 32'h18);
		wr(serial_port_pkg::OFF_IRQ_CLR, 32'h08);
		chk({31'h0, chanIrq}, 32'h1);
		wr(serial_port_pkg::OFF_IRQ_CLR, 32'h10);
		chk({31'h0, chanIrq}, 32'h0);
		wr(serial_port_pkg::OFF_IRQ_SET, 32'h3);
		chk({31'h0, chanIrq}, 32'h0);
		wr(serial_port_pkg::OFF_COMMAND, 32'hC0);
		rchk(serial_port_pkg::OFF_FLAGS, 32'h18);
		wr(serial_port_pkg::OFF_COMMAND, 32'h40);
		rchk(serial_port_pkg::OFF_FLAGS, 32'h21A);
		wr(serial_port_pkg::OFF_COMMAND, 32'h80);
		rchk(serial_port_pkg::OFF_FLAGS, 32'h18);
		wr(serial_port_pkg::OFF_COMMAND, 32'h40);
		wr(serial_port_pkg::OFF_BAUD_DIV, BIT - 1);
		wr(serial_port_pkg::OFF_COMMAND, 32'h200);
		repeat (3 * BIT) @(posedge sys_clk);
		chk({31'h0, txdPin}, 32'h0);
		rd(serial_port_pkg::OFF_FLAGS, v);
		chk(v & 32'h200, 32'h0);
		wr(serial_port_pkg::OFF_COMMAND, 32'h400);
		for (int k = 0; k < 400 && txdPin !== 1'b1; k++) @(posedge sys_clk);
		repeat (9 * BIT) @(posedge sys_clk);
		rd(serial_port_pkg::OFF_FLAGS, v);
		chk((v & 32'h200) | {31'h0, txdPin}, 32'h1);
		for (int k = 0; k < 40 && v[9] !== 1'b1; k++)
			rd(serial_port_pkg::OFF_FLAGS, v);
		chk(v & 32'h200, 32'h200);
		foreach (TXM[i]) txchk(TXM[i], 32'h0, 5 + i, TXE[i]);
		txchk(32'hCC0, 32'h1000, 9, 10'h30B);
		txchk(32'hCC0, 32'h0, 9, 10'h20B);
		wr(serial_port_pkg::OFF_MODE, 32'h8C0);
		wr(serial_port_pkg::OFF_COMMAND, 32'h30);
		serial_line_model_i.send(8'h3C, 1'b1, BIT);
		repeat (2 * BIT) @(posedge sys_clk);
		rd(serial_port_pkg::OFF_FLAGS, v);
		chk(v & 32'h1, 32'h0);
		wr(serial_port_pkg::OFF_COMMAND, 32'h10);
		serial_line_model_i.send(8'h3C, 1'b1, BIT);
		repeat (2 * BIT) @(posedge sys_clk);
		rd(serial_port_pkg::OFF_FLAGS, v);
		chk(v & 32'h1, 32'h1);
		rchk(serial_port_pkg::OFF_RX_HOLD, 32'h3C);
		serial_line_model_i.send(8'h3C, 1'b0, BIT);
		repeat (2 * BIT) @(posedge sys_clk);
		rd(serial_port_pkg::OFF_FLAGS, v);
		chk(v & 32'hE4, 32'h40);
		wr(serial_port_pkg::OFF_COMMAND, 32'h100);
		rd(serial_port_pkg::OFF_FLAGS, v);
		chk(v & 32'hE4, 32'h0);
		serial_line_model_i.level(1'b0);
		foreach (LBM[i]) begin
			wr(serial_port_pkg::OFF_MODE, LBM[i]);
			repeat (8) @(posedge sys_clk);
			chk({31'h0, txdPin}, {31'h0, i == 1});
		end
		serial_line_model_i.level(1'b1);
		wr(serial_port_pkg::OFF_MODE, 32'h8C0);
		serial_line_model_i.modem(4'hA);
		repeat (6) @(posedge sys_clk);
		rd(serial_port_pkg::OFF_MODEM_STATE, v);
		chk(v & 32'hF0, 32'h50);
		close_out();
	end
endmodule
